// ===== logic/phy_cfg_params.svh
// offsets, reset values, write masks and fixed counts of the vendor
// management register bank; assumes a 5-bit management register address
`ifndef PHY_CFG_PARAMS_SVH
`define PHY_CFG_PARAMS_SVH

`define PHY_ADDR_SPECIAL_CFG 5'h14
`define PHY_ADDR_INTR_CTRL 5'h15
`define PHY_ADDR_RX_ERR_CNT 5'h16

`define PHY_SPECIAL_RESET 16'h0000
`define PHY_SPECIAL_WMASK 16'hDE7F
`define PHY_INTR_RESET 16'h0F00
`define PHY_INTR_WMASK 16'h0F00

`define PHY_TRIM_SHORT 5'h0C
`define PHY_TRIM_LONG 5'h16
`define PHY_TRIM_NONE 5'h00

`define PHY_RX_ERR_WIDTH 16
`define PHY_PD_FIELDS 9

`endif

// ===== logic/phy_cfg_pkg.sv
// types of the vendor management register bank
// no assumptions beyond the params header for widths
`default_nettype none

package phy_cfg_pkg;

  // register 20 layout, msb first
  typedef struct packed {
    logic vendor_test_sel_a;
    logic vendor_test_sel_b;
    logic rsvd_13;
    logic vendor_test_sel_c;
    logic preamble_saving_ctrl;
    logic ten_meg_tx_power_save;
    logic autoneg_power_save_disable;
    logic rsvd_8;
    logic crossover_state;
    logic autoneg_digital_loopback;
    logic crossover_fix_value;
    logic crossover_force_enable;
    logic vendor_monitor_sel_hi;
    logic vendor_monitor_sel_lo;
    logic rmii_ver_1_0;
    logic power_down_level;
  } special_cfg_s;

  // register 21 layout, msb first
  typedef struct packed {
    logic irq_pending;
    logic [2:0] rsvd_14_12;
    logic duplex_event_suppress;
    logic speed_event_suppress;
    logic link_event_suppress;
    logic global_irq_suppress;
    logic [2:0] rsvd_7_5;
    logic duplex_changed_flag;
    logic speed_changed_flag;
    logic link_changed_flag;
    logic rsvd_1;
    logic irq_state;
  } intr_ctrl_s;

  // resolved line status from the transceiver core
  typedef struct packed {
    logic duplex;
    logic speed;
    logic link;
  } line_status_s;

endpackage : phy_cfg_pkg

`default_nettype wire

// ===== logic/status_change_detect.sv
// flags a one-cycle change on each bit of a status vector
// assumes the status comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module status_change_detect #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // status and change pulses
  input wire logic [WIDTH-1:0] status_in,
  output logic [WIDTH-1:0] change_out
);

  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] prev_next;
  logic primed_reg;
  logic primed_next;

  always_comb begin
    prev_next = status_in;
    primed_next = 1'b1;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_reg <= '0;
      primed_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      primed_reg <= primed_next;
    end
  end

  // first cycle after reset only captures, so a link already up
  // at reset does not look like a change
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign change_out[i] = primed_reg & (status_in[i] ^ prev_reg[i]);
    end
  endgenerate

endmodule : status_change_detect

`default_nettype wire

// ===== logic/rx_err_counter.sv
// saturating event counter, cleared by a read strobe
// assumes inc and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module rx_err_counter #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // events
  input wire logic inc_in,
  input wire logic clr_in,
  output logic [WIDTH-1:0] count_out
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (clr_in) begin
      // an error in the clearing cycle is kept as the first count
      count_next = {{(WIDTH-1){1'b0}}, inc_in};
    end else if (inc_in && !(&count_reg)) begin
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_out = count_reg;

endmodule : rx_err_counter

`default_nettype wire

// ===== logic/phy_vendor_cfg_regs.sv
// vendor configuration, interrupt and receive error registers of a
// 10/100 transceiver's management block
// assumes status, error and register-29 inputs come from core logic
// on sys_clk_in; bus strobes are one cycle and never overlap
//
// Function
// - bit 11 high keeps normal preamble; low with bit 10 shortens it.
// - shortened preamble drops 12 bits if register 29 bit 11, else 22.
// - register 20 bit 10 enables 10M transmit power saving; resets 0.
// - bit 9 high disables autoneg power saving; zero keeps it enabled.
// - bit 7 read-only, reports crossover state, 1 MDIX, 0 MDI.
// - bit 6 puts autoneg logic in digital loopback; zero is normal.
// - bit 4 high disables automatic crossover; zero keeps it automatic.
// - forced crossover state equals bit 5 while automatic crossover off.
// - bit 1 high selects RMII 1.0, zero selects RMII 1.2.
// - bit 0 gives power-down value for selected register 19 fields.
// - reserved bits read zero and ignore writes.
// - register 21 bit 15 mirrors bit 0 and clears on read.
// - duplex and speed suppress bits block their interrupts; reset to 1.
// - global suppress bit, reset 1, blocks every interrupt.
// - duplex, speed, link change flags latch high, clear on read.
// - bit 0 set when unmasked change flag set; clears on read.
// - 16-bit receive error counter counts errors, clears on read.
// - selected register 19 fields use bit 0 instead of stored value.
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_params.svh"

module phy_vendor_cfg_regs #(
  parameter int PD_FIELDS = `PHY_PD_FIELDS,
  parameter int ERR_WIDTH = `PHY_RX_ERR_WIDTH
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // management register port
  input wire logic [4:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // status from the transceiver core
  input wire phy_cfg_pkg::line_status_s line_status_in,
  input wire logic auto_crossover_state_in,
  input wire logic rx_error_in,
  input wire logic preamble_short_trim_sel_in,
  input wire logic [PD_FIELDS-1:0] vendor_pd_select_in,
  input wire logic [PD_FIELDS-1:0] vendor_pd_stored_in,
  // controls to the transceiver core
  output logic [4:0] tx_preamble_trim_out,
  output logic ten_meg_tx_power_save_out,
  output logic autoneg_power_save_en_out,
  output logic crossover_state_out,
  output logic auto_crossover_en_out,
  output logic autoneg_digital_loopback_out,
  output logic rmii_ver_1_0_out,
  output logic [PD_FIELDS-1:0] pd_effective_out,
  // interrupt pin
  output logic mgmt_irq_n_out
);

  // address match, shared by the write and clear-on-read paths
  function automatic logic addr_hit(input logic [4:0] addr,
                                    input logic [4:0] offset);
    addr_hit = (addr == offset);
  endfunction : addr_hit

  logic wr_special;
  logic wr_intr;
  logic rd_intr;
  logic rd_err;

  assign wr_special = reg_wr_in & addr_hit(reg_addr_in,
                                           `PHY_ADDR_SPECIAL_CFG);
  assign wr_intr = reg_wr_in & addr_hit(reg_addr_in, `PHY_ADDR_INTR_CTRL);
  assign rd_intr = reg_rd_in & addr_hit(reg_addr_in, `PHY_ADDR_INTR_CTRL);
  assign rd_err = reg_rd_in & addr_hit(reg_addr_in, `PHY_ADDR_RX_ERR_CNT);

  // register 20

  phy_cfg_pkg::special_cfg_s special_reg;
  phy_cfg_pkg::special_cfg_s special_next;

  always_comb begin
    special_next = special_reg;
    if (wr_special) begin
      // reserved bits and the read-only state bit drop out here
      special_next = phy_cfg_pkg::special_cfg_s'(
        reg_wdata_in & `PHY_SPECIAL_WMASK);
    end
    // forced value wins over the resolver while auto crossover is off
    if (special_next.crossover_force_enable) begin
      special_next.crossover_state =
        special_next.crossover_fix_value;
    end else begin
      special_next.crossover_state = auto_crossover_state_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      special_reg <= phy_cfg_pkg::special_cfg_s'(`PHY_SPECIAL_RESET);
    end else begin
      special_reg <= special_next;
    end
  end

  // single-bit core controls, one flop each; the two enables are
  // stored already inverted so no output passes through a gate
  logic ten_meg_ps_reg;
  logic ten_meg_ps_next;
  logic an_ps_en_reg;
  logic an_ps_en_next;
  logic xover_state_reg;
  logic xover_state_next;
  logic auto_xover_en_reg;
  logic auto_xover_en_next;
  logic an_loopback_reg;
  logic an_loopback_next;
  logic rmii_1_0_reg;
  logic rmii_1_0_next;

  always_comb begin
    ten_meg_ps_next = special_next.ten_meg_tx_power_save;
    an_ps_en_next = ~special_next.autoneg_power_save_disable;
    xover_state_next = special_next.crossover_state;
    auto_xover_en_next = ~special_next.crossover_force_enable;
    an_loopback_next = special_next.autoneg_digital_loopback;
    rmii_1_0_next = special_next.rmii_ver_1_0;
  end

  // reset values match the register 20 reset word
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ten_meg_ps_reg <= 1'b0;
      an_ps_en_reg <= 1'b1;
      xover_state_reg <= 1'b0;
      auto_xover_en_reg <= 1'b1;
      an_loopback_reg <= 1'b0;
      rmii_1_0_reg <= 1'b0;
    end else begin
      ten_meg_ps_reg <= ten_meg_ps_next;
      an_ps_en_reg <= an_ps_en_next;
      xover_state_reg <= xover_state_next;
      auto_xover_en_reg <= auto_xover_en_next;
      an_loopback_reg <= an_loopback_next;
      rmii_1_0_reg <= rmii_1_0_next;
    end
  end

  // register 21

  phy_cfg_pkg::intr_ctrl_s intr_reg;
  phy_cfg_pkg::intr_ctrl_s intr_next;
  logic [2:0] change_pulse;
  logic [2:0] event_enable;
  logic [2:0] flags_next;

  status_change_detect #(
    .WIDTH(3)
  ) u_change (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .status_in(line_status_in),
    .change_out(change_pulse)
  );

  always_comb begin
    intr_next = intr_reg;
    if (wr_intr) begin
      {intr_next.duplex_event_suppress,
       intr_next.speed_event_suppress,
       intr_next.link_event_suppress,
       intr_next.global_irq_suppress} =
        reg_wdata_in[11:8];
    end
    // a change in the read cycle survives the clear
    flags_next = {intr_reg.duplex_changed_flag,
                  intr_reg.speed_changed_flag,
                  intr_reg.link_changed_flag};
    if (rd_intr) begin
      flags_next = 3'h0;
    end
    flags_next = flags_next | change_pulse;
    {intr_next.duplex_changed_flag,
     intr_next.speed_changed_flag,
     intr_next.link_changed_flag} = flags_next;
    event_enable = ~{intr_next.duplex_event_suppress,
                     intr_next.speed_event_suppress,
                     intr_next.link_event_suppress};
    intr_next.irq_state = intr_reg.irq_state & ~rd_intr;
    if (!intr_next.global_irq_suppress &&
        |(flags_next & event_enable)) begin
      intr_next.irq_state = 1'b1;
    end
    intr_next.irq_pending = intr_next.irq_state;
    intr_next.rsvd_14_12 = 3'h0;
    intr_next.rsvd_7_5 = 3'h0;
    intr_next.rsvd_1 = 1'b0;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      intr_reg <= phy_cfg_pkg::intr_ctrl_s'(`PHY_INTR_RESET);
    end else begin
      intr_reg <= intr_next;
    end
  end

  // register 22

  logic [ERR_WIDTH-1:0] err_count;

  rx_err_counter #(
    .WIDTH(ERR_WIDTH)
  ) u_err_count (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .inc_in(rx_error_in),
    .clr_in(rd_err),
    .count_out(err_count)
  );

  // read data, valid only in the cycle after the strobe

  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_comb begin
    rdata_next = 16'h0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `PHY_ADDR_SPECIAL_CFG: rdata_next = special_reg;
        `PHY_ADDR_INTR_CTRL: rdata_next = intr_reg;
        `PHY_ADDR_RX_ERR_CNT: rdata_next = 16'(err_count);
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // derived controls, registered so every output leaves a flop

  logic [4:0] trim_reg;
  logic [4:0] trim_next;
  logic [PD_FIELDS-1:0] pd_reg;
  logic [PD_FIELDS-1:0] pd_next;
  logic irq_n_reg;
  logic irq_n_next;

  genvar g;
  generate
    for (g = 0; g < PD_FIELDS; g++) begin : g_pd
      assign pd_next[g] = vendor_pd_select_in[g] ?
        special_next.power_down_level :
        vendor_pd_stored_in[g];
    end
  endgenerate

  always_comb begin
    trim_next = `PHY_TRIM_NONE;
    if (special_next.ten_meg_tx_power_save &&
        !special_next.preamble_saving_ctrl) begin
      trim_next = preamble_short_trim_sel_in ?
        `PHY_TRIM_SHORT : `PHY_TRIM_LONG;
    end
    // pin follows the status flop exactly, no extra cycle of lag
    irq_n_next = ~intr_next.irq_state;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      trim_reg <= `PHY_TRIM_NONE;
      pd_reg <= '0;
      irq_n_reg <= 1'b1;
    end else begin
      trim_reg <= trim_next;
      pd_reg <= pd_next;
      irq_n_reg <= irq_n_next;
    end
  end

  assign tx_preamble_trim_out = trim_reg;
  assign pd_effective_out = pd_reg;
  assign mgmt_irq_n_out = irq_n_reg;
  assign ten_meg_tx_power_save_out = ten_meg_ps_reg;
  assign autoneg_power_save_en_out = an_ps_en_reg;
  assign crossover_state_out = xover_state_reg;
  assign auto_crossover_en_out = auto_xover_en_reg;
  assign autoneg_digital_loopback_out = an_loopback_reg;
  assign rmii_ver_1_0_out = rmii_1_0_reg;

endmodule : phy_vendor_cfg_regs

`default_nettype wire

// ===== tb/phy_vendor_cfg_regs_sva.sv
// assertions on the vendor register bank ports
// assumes one clock domain and the one-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_params.svh"

module phy_vendor_cfg_regs_sva (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [4:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  // core side
  input wire phy_cfg_pkg::line_status_s line_status_in,
  input wire logic auto_crossover_state_in,
  input wire logic rx_error_in,
  input wire logic crossover_state_out,
  input wire logic auto_crossover_en_out,
  input wire logic mgmt_irq_n_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  logic mask_reg;
  logic mask_next;
  wire logic wr_int = reg_wr_in && reg_addr_in == `PHY_ADDR_INTR_CTRL;
  wire logic rd_cfg = reg_rd_in && reg_addr_in == `PHY_ADDR_SPECIAL_CFG;
  wire logic rd_int = reg_rd_in && reg_addr_in == `PHY_ADDR_INTR_CTRL;
  wire logic rd_cnt = reg_rd_in && reg_addr_in == `PHY_ADDR_RX_ERR_CNT;

  // shadow of the global suppress bit, reset value set
  always_comb begin
    mask_next = mask_reg;
    if (wr_int) begin
      mask_next = reg_wdata_in[8];
    end
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask_reg <= 1'b1;
    end else begin
      mask_reg <= mask_next;
    end
  end

  chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property (reg_rd_in && !rd_cfg && !rd_int
    && !rd_cnt |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  chk_cfg_reserved: assert property (rd_cfg |=>
    reg_rdata_out[13] == 1'b0 && reg_rdata_out[8] == 1'b0)
    else $error("reserved config bits not zero");
  chk_int_reserved: assert property (rd_int |=>
    reg_rdata_out[14:12] == 3'h0 && reg_rdata_out[7:5] == 3'h0
    && reg_rdata_out[1] == 1'b0)
    else $error("reserved interrupt bits not zero");
  chk_pin_mirror: assert property (rd_int |=> reg_rdata_out[15] ==
    reg_rdata_out[0] && reg_rdata_out[0] == !$past(mgmt_irq_n_out))
    else $error("pending, status and pin disagree");
  chk_irq_clear: assert property (
    (rd_int && $stable(line_status_in)) ##1 $stable(line_status_in)
    |-> mgmt_irq_n_out)
    else $error("pin not released after status read");
  chk_global_mask: assert property (
    mask_reg && mgmt_irq_n_out && !wr_int |=> mgmt_irq_n_out)
    else $error("interrupt raised while globally suppressed");
  chk_err_clear: assert property (
    (rd_cnt && !rx_error_in) ##1 rd_cnt |=> reg_rdata_out == 16'h0000)
    else $error("error count not cleared by read");
  // the release edge itself still shows the reset value of the state
  chk_auto_follow: assert property (
    resetn_in && auto_crossover_en_out && !reg_wr_in
    |=> crossover_state_out == $past(auto_crossover_state_in))
    else $error("crossover state not following resolver");
endmodule : phy_vendor_cfg_regs_sva

bind phy_vendor_cfg_regs phy_vendor_cfg_regs_sva chk_u (.sys_clk_in,
  .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .line_status_in, .auto_crossover_state_in, .rx_error_in,
  .crossover_state_out, .auto_crossover_en_out, .mgmt_irq_n_out);

`default_nettype wire

// ===== tb/phy_vendor_cfg_regs_tb_top.sv
// self-checking bench for the vendor register bank
// drives every port itself; one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_params.svh"

module phy_vendor_cfg_regs_tb_top;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] reg_addr_in = 5'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  phy_cfg_pkg::line_status_s line_status_in = 3'h0;
  logic auto_crossover_state_in = 1'b1;
  logic rx_error_in = 1'b0;
  logic preamble_short_trim_sel_in = 1'b1;
  logic [8:0] vendor_pd_select_in = 9'h0F0;
  logic [8:0] vendor_pd_stored_in = 9'h10F;
  logic [4:0] tx_preamble_trim_out;
  logic ten_meg_tx_power_save_out, autoneg_power_save_en_out;
  logic crossover_state_out, auto_crossover_en_out, rmii_ver_1_0_out;
  logic autoneg_digital_loopback_out, mgmt_irq_n_out;
  logic [8:0] pd_effective_out;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;

  phy_vendor_cfg_regs dut_u (.sys_clk_in, .resetn_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .line_status_in,
    .auto_crossover_state_in, .rx_error_in, .preamble_short_trim_sel_in,
    .vendor_pd_select_in, .vendor_pd_stored_in, .tx_preamble_trim_out,
    .ten_meg_tx_power_save_out, .autoneg_power_save_en_out,
    .crossover_state_out, .auto_crossover_en_out,
    .autoneg_digital_loopback_out, .rmii_ver_1_0_out, .pd_effective_out,
    .mgmt_irq_n_out);

  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : idle

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check(reg_rdata_out, exp);
  endtask : rd

  // packed view of the single-bit controls, msb first
  function automatic logic [15:0] ctl();
    return {10'h000, ten_meg_tx_power_save_out, autoneg_power_save_en_out,
      crossover_state_out, auto_crossover_en_out,
      autoneg_digital_loopback_out, rmii_ver_1_0_out};
  endfunction : ctl

  task automatic end_of_test();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // hang guard, far above the 70 or so cycles the sequence needs
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    rd(`PHY_ADDR_SPECIAL_CFG, 16'h0080);
    check(ctl(), 16'h001C);
    rd(`PHY_ADDR_INTR_CTRL, 16'h0F00);
    rd(`PHY_ADDR_RX_ERR_CNT, 16'h0000);
    rd(5'h13, 16'h0000);
    wr(`PHY_ADDR_SPECIAL_CFG, 16'hFFDF);
    rd(`PHY_ADDR_SPECIAL_CFG, 16'hDE5F);
    check(ctl(), 16'h0023);
    check({7'h00, pd_effective_out}, 16'h01FF);
    check({11'h000, tx_preamble_trim_out}, 16'h0000);
    wr(`PHY_ADDR_SPECIAL_CFG, 16'h0400);
    idle(2);
    check(ctl(), 16'h003C);
    check({7'h00, pd_effective_out}, 16'h010F);
    check({11'h000, tx_preamble_trim_out}, 16'h000C);
    @(posedge sys_clk_in);
    preamble_short_trim_sel_in <= 1'b0;
    idle(3);
    check({11'h000, tx_preamble_trim_out}, 16'h0016);
    @(posedge sys_clk_in);
    line_status_in.link <= 1'b1;
    idle(4);
    check({15'h0000, mgmt_irq_n_out}, 16'h0001);
    rd(`PHY_ADDR_INTR_CTRL, 16'h0F04);
    wr(`PHY_ADDR_INTR_CTRL, 16'h0000);
    line_status_in.duplex <= 1'b1;
    idle(4);
    check({15'h0000, mgmt_irq_n_out}, 16'h0000);
    rd(`PHY_ADDR_INTR_CTRL, 16'h8011);
    check({15'h0000, mgmt_irq_n_out}, 16'h0001);
    rd(`PHY_ADDR_INTR_CTRL, 16'h0000);
    wr(`PHY_ADDR_INTR_CTRL, 16'h0400);
    line_status_in.speed <= 1'b1;
    idle(4);
    check({15'h0000, mgmt_irq_n_out}, 16'h0001);
    rd(`PHY_ADDR_INTR_CTRL, 16'h0408);
    wr(`PHY_ADDR_INTR_CTRL, 16'h0100);
    line_status_in.link <= 1'b0;
    idle(4);
    check({15'h0000, mgmt_irq_n_out}, 16'h0001);
    rd(`PHY_ADDR_INTR_CTRL, 16'h0104);
    @(posedge sys_clk_in);
    rx_error_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rx_error_in <= 1'b0;
    reg_addr_in <= `PHY_ADDR_RX_ERR_CNT;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    #1;
    check(reg_rdata_out, 16'h0003);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check(reg_rdata_out, 16'h0000);
    @(posedge sys_clk_in);
    auto_crossover_state_in <= 1'b0;
    rd(`PHY_ADDR_SPECIAL_CFG, 16'h0400);
    check(ctl(), 16'h0034);
    idle(2);
    end_of_test();
  end
endmodule : phy_vendor_cfg_regs_tb_top

`default_nettype wire
